// File: bench/apc_ctrl_tb_top.sv
// self-checking bench for the audio port clock and pin control
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module apc_ctrl_tb_top;
    import apc_pkg::*;
    logic       i_clk, i_nrst, i_reg_wr, i_reg_rd, mclk, pz, p2, pz_out, p2_out, mute, src_en, src_val, inv;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, bhalf, fhalf;
    logic       o_bit_clock, o_bit_clock_oe, o_frame_clock, o_frame_clock_oe, o_pin_zero, o_pin_zero_oe;
    logic       o_pin_two, o_pin_two_oe, o_pin_zero_in, o_pin_two_in, o_amp_mute, o_bit_strobe, o_sample_data;
    logic       o_sample_frame, src_bclk, src_fclk, src_data, bpin, fpin;
    int         n_fail, checks_done, mcnt, bcnt, m0;
    // pin levels resolved from the controller's output enables
    assign bpin = o_bit_clock_oe ? o_bit_clock : src_bclk;
    assign fpin = o_frame_clock_oe ? o_frame_clock : src_fclk;
    apc_ctrl i_apc_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_bit_half(bhalf),
        .i_frame_half(fhalf), .i_master_clock(mclk), .i_serial_data(src_data), .i_bit_clock(bpin),
        .o_bit_clock(o_bit_clock), .o_bit_clock_oe(o_bit_clock_oe), .i_frame_clock(fpin),
        .o_frame_clock(o_frame_clock), .o_frame_clock_oe(o_frame_clock_oe),
        .i_pin_zero(o_pin_zero_oe ? o_pin_zero : pz), .o_pin_zero(o_pin_zero), .o_pin_zero_oe(o_pin_zero_oe),
        .i_pin_zero_out(pz_out), .o_pin_zero_in(o_pin_zero_in), .i_pin_two(o_pin_two_oe ? o_pin_two : p2),
        .o_pin_two(o_pin_two), .o_pin_two_oe(o_pin_two_oe), .i_pin_two_out(p2_out), .o_pin_two_in(o_pin_two_in),
        .i_conv_mute(mute), .o_amp_mute(o_amp_mute), .o_bit_strobe(o_bit_strobe), .o_sample_data(o_sample_data),
        .o_sample_frame(o_sample_frame));
    apc_src_model i_apc_src_model (.i_en(src_en), .i_invert(inv), .i_val(src_val), .i_bclk(bpin),
        .o_bclk(src_bclk), .o_fclk(src_fclk), .o_data(src_data));
    ////////////////////////////////////////////////////////////////////////
    // clock, master clock at one sixteenth of the system rate, edge counters
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always
    begin
        repeat (8) @(negedge i_clk);
        mclk <= ~mclk;
    end
    always @(posedge mclk) mcnt++;
    always @(posedge bpin) bcnt++;
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        `CHK("rdata", e, o_reg_rdata)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wait_strobe();
        do @(negedge i_clk); while (o_bit_strobe !== 1'b1);
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(APC_ADDR_PIN_DIR, 8'h00);
        rd(APC_ADDR_CLK_CFG, 8'h00);
        rd(APC_ADDR_DIV_RESET, 8'h01);
        wr(APC_ADDR_PIN_DIR, 8'hff);
        rd(APC_ADDR_PIN_DIR, 8'hff);
        wr(APC_ADDR_CLK_CFG, 8'hff);
        rd(APC_ADDR_CLK_CFG, 8'h31);
        `CHK("fclk_oe", 1'b1, o_frame_clock_oe)
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        wr(APC_ADDR_CLK_CFG, 8'h00);
        `CHK("bclk_oe", 1'b0, o_bit_clock_oe)
    endtask
    task automatic t_pins();
        pz_out = 1'b1;
        wr(APC_ADDR_PIN_DIR, 8'h38);
        cyc(6);
        `CHK("pin0", 1'b1, o_pin_zero_in)
        `CHK("pin2", 1'b0, o_pin_two)
        `CHK("mute", 1'b1, o_amp_mute)
        `CHK("pin0 drive", 1'b1, o_pin_zero)
        `CHK("dirs out", 2'b11, {o_pin_two_oe, o_pin_zero_oe})
        wr(APC_ADDR_PIN_DIR, 8'h00);
        pz = 1'b0;
        p2 = 1'b1;
        cyc(6);
        `CHK("pin0 in", 1'b0, o_pin_zero_in)
        `CHK("pin2 in", 1'b1, o_pin_two_in)
        `CHK("mute off", 1'b0, o_amp_mute)
        `CHK("dirs in", 2'b00, {o_pin_two_oe, o_pin_zero_oe})
    endtask
    task automatic t_master();
        int nf = 0;
        wr(APC_ADDR_DIV_RESET, 8'h00);
        wr(APC_ADDR_CLK_CFG, 8'h11);
        cyc(300);
        `CHK("bclk held", 1'b0, o_bit_clock)
        wr(APC_ADDR_DIV_RESET, 8'h03);
        src_val = 1'b1;
        src_en = 1'b1;
        @(posedge o_bit_clock);
        m0 = mcnt;
        @(posedge o_bit_clock);
        `CHK("mclk per bclk", 2 * int'(bhalf), mcnt - m0)
        @(posedge o_frame_clock);
        m0 = bcnt;
        @(posedge o_frame_clock);
        `CHK("bclk per frame", 2 * int'(fhalf), bcnt - m0)
        wait_strobe();
        wait_strobe();
        `CHK("master data", 1'b1, o_sample_data)
        // two whole frames of samples hold the frame level high for exactly half of them
        repeat (4 * int'(fhalf))
        begin
            wait_strobe();
            nf += int'(o_sample_frame);
        end
        `CHK("master frame", 2 * int'(fhalf), nf)
        wr(APC_ADDR_DIV_RESET, 8'h02);
        cyc(300);
        `CHK("fclk held", 1'b0, o_frame_clock)
        src_en = 1'b0;
        wr(APC_ADDR_CLK_CFG, 8'h00);
    endtask
    task automatic t_slave(input logic v, input logic pol);
        int nf = 0;
        inv = pol;
        src_val = v;
        wr(APC_ADDR_CLK_CFG, {2'b00, pol, 5'h00});
        src_en = 1'b1;
        repeat (2) wait_strobe();
        // the source flips its frame every four bits, so eight samples hold four high
        repeat (8)
        begin
            wait_strobe();
            nf += int'(o_sample_frame);
            `CHK("slave data", v, o_sample_data)
        end
        `CHK("slave frame", 4, nf)
        `CHK("no drive", 2'b00, {o_bit_clock_oe, o_frame_clock_oe})
        src_en = 1'b0;
    endtask
    // reset in mid-run must bring the pin direction and divider reset registers back to their reset values
    task automatic t_rst();
        wr(APC_ADDR_PIN_DIR, 8'hff);
        wr(APC_ADDR_DIV_RESET, 8'h00);
        @(negedge i_clk);
        i_nrst = 1'b0;
        cyc(2);
        i_nrst = 1'b1;
        rd(APC_ADDR_PIN_DIR, APC_PIN_DIR_RST);
        rd(APC_ADDR_DIV_RESET, APC_DIV_RESET_RST);
        `CHK("oe after reset", 2'b00, {o_pin_two_oe, o_pin_zero_oe})
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the expected 10 us run
    initial
    begin
        #200us;
        n_fail++;
        close_out();
    end
    initial
    begin
        {i_nrst, i_reg_wr, i_reg_rd, mclk, pz, p2, pz_out, p2_out, mute, src_en, src_val, inv} = '0;
        {i_reg_addr, i_reg_wdata} = '0;
        bhalf = 8'h02;
        fhalf = 8'h02;
        n_fail = 0;
        checks_done = 0;
        mute = 1'b1;
        cyc(4);
        i_nrst = 1'b1;
        t_regs();
        t_pins();
        t_master();
        t_slave(1'b1, 1'b0);
        t_slave(1'b0, 1'b1);
        t_rst();
        close_out();
    end
endmodule

// File: bench/apc_src_model.sv
// behavioural external audio source feeding the serial port
`timescale 1ns/1ps
module apc_src_model #(
    parameter int HALF_NS = 40
) (
    // control from the bench
    input  wire logic i_en,
    input  wire logic i_invert,
    input  wire logic i_val,
    // resolved bit clock pin
    input  wire logic i_bclk,
    // source pins
    output logic      o_bclk,
    output logic      o_fclk,
    output logic      o_data
);
    int nbit;
    initial
    begin
        o_bclk = 1'b0;
        o_fclk = 1'b0;
        o_data = 1'b0;
        nbit = 0;
    end
    // own bit clock stands low while disabled
    always
    begin
        #HALF_NS;
        o_bclk = i_en ? ~o_bclk : 1'b0;
    end
    // released lines keep changing so no stale level is read
    always
    begin
        #6;
        if (!i_en)
        begin
            o_data = ~o_data;
            o_fclk = ~o_fclk;
        end
    end
    // launch on the edge the polarity names; junk once hold runs out
    always @(i_bclk)
    begin
        if (i_en && i_bclk == i_invert)
        begin
            o_data = i_val;
            nbit++;
            if (nbit % 4 == 0)
                o_fclk = ~o_fclk;
        end
        else if (i_en)
            o_data <= #8 ~i_val;
    end
endmodule

// File: rtl/apc_clk_div.sv
// clock divider: toggles its output every half-count input ticks, held low while stopped
`timescale 1ns/1ps
module apc_clk_div #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // control
    input  wire logic             i_run,
    input  wire logic             i_tick,
    input  wire logic [DIV_W-1:0] i_half,
    // divided level
    output logic                  o_level
);
    if (DIV_W < 2)
    begin : g_chk
        $error("apc_clk_div: DIV_W must be at least 2");
    end

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             level;
    } apc_div_state_t;

    apc_div_state_t st_q;
    apc_div_state_t st_d;
    logic [DIV_W-1:0] last;

    // a zero half count is served as one, so the divider never stalls
    assign last = (i_half == '0) ? '0 : i_half - DIV_W'(1);

    // count ticks; the stopped divider restarts from a known phase
    always_comb
    begin
        st_d = st_q;
        if (!i_run)
        begin
            st_d.cnt   = '0;
            st_d.level = 1'b0;
        end
        else if (i_tick)
        begin
            if (st_q.cnt >= last)
            begin
                st_d.cnt   = '0;
                st_d.level = ~st_q.level;
            end
            else
            begin
                st_d.cnt = st_q.cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_level = st_q.level;
endmodule

// File: rtl/apc_ctrl.sv
// audio port clock direction, divider and general pin control
`timescale 1ns/1ps
module apc_ctrl
    import apc_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // byte register port
    input  wire logic [7:0]       i_reg_addr,
    input  wire logic             i_reg_wr,
    input  wire logic             i_reg_rd,
    input  wire logic [7:0]       i_reg_wdata,
    output logic [7:0]            o_reg_rdata,
    // divider ratios, given as half periods in input ticks
    input  wire logic [DIV_W-1:0] i_bit_half,
    input  wire logic [DIV_W-1:0] i_frame_half,
    // master clock and serial data pins
    input  wire logic             i_master_clock,
    input  wire logic             i_serial_data,
    // bit clock pin
    input  wire logic             i_bit_clock,
    output logic                  o_bit_clock,
    output logic                  o_bit_clock_oe,
    // frame clock pin
    input  wire logic             i_frame_clock,
    output logic                  o_frame_clock,
    output logic                  o_frame_clock_oe,
    // general pin zero
    input  wire logic             i_pin_zero,
    output logic                  o_pin_zero,
    output logic                  o_pin_zero_oe,
    input  wire logic             i_pin_zero_out,
    output logic                  o_pin_zero_in,
    // general pin two
    input  wire logic             i_pin_two,
    output logic                  o_pin_two,
    output logic                  o_pin_two_oe,
    input  wire logic             i_pin_two_out,
    output logic                  o_pin_two_in,
    // mute hand-off
    input  wire logic             i_conv_mute,
    output logic                  o_amp_mute,
    // captured serial stream
    output logic                  o_bit_strobe,
    output logic                  o_sample_data,
    output logic                  o_sample_frame
);
    import apc_pkg::*;

    if (DIV_W < 2)
    begin : g_chk
        $error("apc_ctrl: DIV_W must be at least 2");
    end

    typedef struct packed {
        logic [APC_SYNC_N-1:0] s1;
        logic [APC_SYNC_N-1:0] s2;
        logic [APC_SYNC_N-1:0] s3;
        logic [APC_SYNC_N-1:0] stab;
        logic                  mclk_edge;
        logic [7:0]            pin_dir;
        logic [7:0]            clk_cfg;
        logic [7:0]            div_rst;
        logic [7:0]            rdata;
        logic                  bclk_prev;
        logic                  bit_strobe;
        logic                  sdata;
        logic                  sframe;
        logic                  amp_mute;
    } apc_state_t;

    apc_state_t st_q;
    apc_state_t st_d;

    logic bdiv_level;
    logic fdiv_level;
    logic bclk_eff;
    logic fclk_eff;
    logic bclk_rise;
    logic bclk_fall;
    logic launch_edge;
    logic sample_edge;
    logic master_bclk;
    logic master_fclk;
    logic inv;

    // read mux shared by the register port
    function automatic logic [7:0] apc_read(input logic [7:0] addr, input apc_state_t s);
        case (addr)
            APC_ADDR_PIN_DIR:   apc_read = s.pin_dir;
            APC_ADDR_CLK_CFG:   apc_read = s.clk_cfg & APC_CLK_CFG_MASK;
            APC_ADDR_DIV_RESET: apc_read = s.div_rst;
            default:            apc_read = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // clock selection and edge decode

    assign master_bclk = st_q.clk_cfg[APC_BCLK_OE_BIT];
    assign master_fclk = st_q.clk_cfg[APC_FCLK_OE_BIT];
    assign inv         = st_q.clk_cfg[APC_BCLK_INVERT_BIT];
    // master uses its own divided clock, slave the filtered pin
    assign bclk_eff    = master_bclk ? bdiv_level : st_q.stab[APC_S_BCLK];
    assign fclk_eff    = master_fclk ? fdiv_level : st_q.stab[APC_S_FCLK];
    assign bclk_rise   = bclk_eff & ~st_q.bclk_prev;
    assign bclk_fall   = ~bclk_eff & st_q.bclk_prev;
    // edge where frame and data change, and the opposite one where they are taken
    assign launch_edge = inv ? bclk_rise : bclk_fall;
    assign sample_edge = inv ? bclk_fall : bclk_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // master mode dividers

    apc_clk_div #(
        .DIV_W   (DIV_W)
    ) u_bit_div (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_run   (st_q.div_rst[APC_BIT_DIV_RUN_BIT]),
        .i_tick  (st_q.mclk_edge),
        .i_half  (i_bit_half),
        .o_level (bdiv_level)
    );

    // frame divider steps on the launch edge so frame transitions line up with data
    apc_clk_div #(
        .DIV_W   (DIV_W)
    ) u_frame_div (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_run   (st_q.div_rst[APC_FRAME_DIV_RUN_BIT]),
        .i_tick  (launch_edge & master_bclk),
        .i_half  (i_frame_half),
        .o_level (fdiv_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        st_d = st_q;
        // three-stage synchronisers; a level is accepted once stages two and three agree
        st_d.s1 = {i_pin_two, i_pin_zero, i_serial_data, i_frame_clock, i_bit_clock, i_master_clock};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < APC_SYNC_N; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
                st_d.stab[i] = st_q.s3[i];
        end
        st_d.mclk_edge = st_d.stab[APC_S_MCLK] & ~st_q.stab[APC_S_MCLK];
        // register writes; unmapped offsets are ignored
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                APC_ADDR_PIN_DIR:   st_d.pin_dir = i_reg_wdata;
                APC_ADDR_CLK_CFG:   st_d.clk_cfg = i_reg_wdata & APC_CLK_CFG_MASK;
                APC_ADDR_DIV_RESET: st_d.div_rst = i_reg_wdata;
                default:            st_d.div_rst = st_q.div_rst;
            endcase
        end
        if (i_reg_rd)
            st_d.rdata = apc_read(i_reg_addr, st_q);
        // serial capture on the edge away from the transitions
        st_d.bclk_prev  = bclk_eff;
        st_d.bit_strobe = sample_edge;
        if (sample_edge)
        begin
            st_d.sdata  = st_q.stab[APC_S_DATA];
            st_d.sframe = fclk_eff;
        end
        st_d.amp_mute = st_q.pin_dir[APC_MUTE_LINK_BIT] & i_conv_mute;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            st_q         <= '0;
            st_q.pin_dir <= APC_PIN_DIR_RST;
            st_q.clk_cfg <= APC_CLK_CFG_RST;
            st_q.div_rst <= APC_DIV_RESET_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins and outputs

    // enables come straight from the config flops, so an input pin is never driven
    assign o_bit_clock      = master_bclk & bdiv_level;
    assign o_bit_clock_oe   = master_bclk;
    assign o_frame_clock    = master_fclk & fdiv_level;
    assign o_frame_clock_oe = master_fclk;
    assign o_pin_zero       = i_pin_zero_out;
    assign o_pin_zero_oe    = st_q.pin_dir[APC_PIN_ZERO_DIR_BIT];
    assign o_pin_zero_in    = st_q.stab[APC_S_PIN0];
    assign o_pin_two        = i_pin_two_out;
    assign o_pin_two_oe     = st_q.pin_dir[APC_PIN_TWO_DIR_BIT];
    assign o_pin_two_in     = st_q.stab[APC_S_PIN2];
    assign o_amp_mute       = st_q.amp_mute;
    assign o_reg_rdata      = st_q.rdata;
    assign o_bit_strobe     = st_q.bit_strobe;
    assign o_sample_data    = st_q.sdata;
    assign o_sample_frame   = st_q.sframe;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_pin_two;
        i_reg_wr && i_reg_addr == APC_ADDR_PIN_DIR |=> o_pin_two_oe == $past(i_reg_wdata[APC_PIN_TWO_DIR_BIT]);
    endproperty
    a_pin_two: assert property (p_pin_two) else $error("pin two direction not taken");

    property p_mute;
        !st_q.pin_dir[APC_MUTE_LINK_BIT] ##1 !st_q.pin_dir[APC_MUTE_LINK_BIT] |-> !o_amp_mute;
    endproperty
    a_mute: assert property (p_mute) else $error("mute passed while link disabled");

    property p_mute_pass;
        i_conv_mute && st_q.pin_dir[APC_MUTE_LINK_BIT] |=> o_amp_mute;
    endproperty
    a_mute_pass: assert property (p_mute_pass) else $error("mute not passed while link enabled");

    property p_pin_zero;
        i_reg_wr && i_reg_addr == APC_ADDR_PIN_DIR |=> o_pin_zero_oe == $past(i_reg_wdata[APC_PIN_ZERO_DIR_BIT]);
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("pin zero direction not taken");

    property p_strobe_edge;
        o_bit_strobe |-> ($past(inv) ? !$past(bclk_eff) && $past(st_q.bclk_prev)
                                     : $past(bclk_eff) && !$past(st_q.bclk_prev));
    endproperty
    a_strobe_edge: assert property (p_strobe_edge) else $error("sample taken on wrong edge");

    // the filtered clock cannot move on two edges in a row, so a strobe is one cycle wide
    property p_strobe_pulse;
        o_bit_strobe |=> !o_bit_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("sample strobe longer than one cycle");

    property p_bclk_release;
        i_reg_wr && i_reg_addr == APC_ADDR_CLK_CFG && !i_reg_wdata[APC_BCLK_OE_BIT] |=> !o_bit_clock_oe && !o_bit_clock;
    endproperty
    a_bclk_release: assert property (p_bclk_release) else $error("bit clock driven as input");

    property p_rd_cfg;
        i_reg_rd && !i_reg_wr && i_reg_addr == APC_ADDR_CLK_CFG |=> o_reg_rdata[APC_BCLK_OE_BIT] == o_bit_clock_oe;
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("bit clock direction read back wrong");

    property p_fclk_release;
        i_reg_wr && i_reg_addr == APC_ADDR_CLK_CFG && !i_reg_wdata[APC_FCLK_OE_BIT] |=> !o_frame_clock_oe && !o_frame_clock;
    endproperty
    a_fclk_release: assert property (p_fclk_release) else $error("frame clock driven as input");

    property p_bdiv_step;
        $changed(bdiv_level) && $past(st_q.div_rst[APC_BIT_DIV_RUN_BIT]) |-> $past(st_q.mclk_edge);
    endproperty
    a_bdiv_step: assert property (p_bdiv_step) else $error("bit clock moved without master clock edge");

    property p_bdiv_hold;
        !st_q.div_rst[APC_BIT_DIV_RUN_BIT] |=> !bdiv_level;
    endproperty
    a_bdiv_hold: assert property (p_bdiv_hold) else $error("bit divider ran while held");

    property p_fdiv_hold;
        !st_q.div_rst[APC_FRAME_DIV_RUN_BIT] |=> !fdiv_level;
    endproperty
    a_fdiv_hold: assert property (p_fdiv_hold) else $error("frame divider ran while held");

    property p_fdiv_step;
        $changed(fdiv_level) && $past(st_q.div_rst[APC_FRAME_DIV_RUN_BIT]) |-> $past(launch_edge && master_bclk);
    endproperty
    a_fdiv_step: assert property (p_fdiv_step) else $error("frame clock moved off a launch edge");

    // a slave bit clock gives the frame divider no ticks at all
    property p_fdiv_slave;
        !master_bclk && st_q.div_rst[APC_FRAME_DIV_RUN_BIT] |=> $stable(fdiv_level);
    endproperty
    a_fdiv_slave: assert property (p_fdiv_slave) else $error("frame divider stepped on a slave bit clock");

    // unmapped offsets read back as zero
    property p_rd_unmapped;
        i_reg_rd && i_reg_addr != APC_ADDR_PIN_DIR && i_reg_addr != APC_ADDR_CLK_CFG
            && i_reg_addr != APC_ADDR_DIV_RESET |=> o_reg_rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped offset read not zero");
endmodule

// File: rtl/apc_pkg.sv
// shared register map and field layout for the audio port clock/direction control
package apc_pkg;
    // register offsets
    localparam logic [7:0] APC_ADDR_PIN_DIR   = 8'h08;
    localparam logic [7:0] APC_ADDR_CLK_CFG   = 8'h09;
    localparam logic [7:0] APC_ADDR_DIV_RESET = 8'h0c;
    // pin_direction_ctrl fields
    localparam int APC_PIN_TWO_DIR_BIT   = 5;
    localparam int APC_MUTE_LINK_BIT     = 4;
    localparam int APC_PIN_ZERO_DIR_BIT  = 3;
    // audio_port_clock_cfg fields
    localparam int APC_BCLK_INVERT_BIT   = 5;
    localparam int APC_BCLK_OE_BIT       = 4;
    localparam int APC_FCLK_OE_BIT       = 0;
    localparam logic [7:0] APC_CLK_CFG_MASK = 8'h31;
    // master_divider_reset fields
    localparam int APC_BIT_DIV_RUN_BIT   = 1;
    localparam int APC_FRAME_DIV_RUN_BIT = 0;
    // reset values
    localparam logic [7:0] APC_PIN_DIR_RST   = 8'h00;
    localparam logic [7:0] APC_CLK_CFG_RST   = 8'h00;
    localparam logic [7:0] APC_DIV_RESET_RST = 8'h01;
    // synchroniser lanes: master clock, bit clock, frame clock, data, pin zero, pin two
    localparam int APC_SYNC_N   = 6;
    localparam int APC_S_MCLK   = 0;
    localparam int APC_S_BCLK   = 1;
    localparam int APC_S_FCLK   = 2;
    localparam int APC_S_DATA   = 3;
    localparam int APC_S_PIN0   = 4;
    localparam int APC_S_PIN2   = 5;
endpackage
